// >>> common/usc_pkg.sv
// Constants, field layout and pin carrier of the serial shift control block
package usc_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] PLACE_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] DATA_OFS = 8'h0c;
   localparam logic [7:0] PORT_OFS = 8'h10;

   // Control register fields
   localparam int CTRL_SIE = 7;
   localparam int CTRL_OIE = 6;
   localparam int CTRL_WM_LO = 4;
   localparam int CTRL_CS_LO = 2;
   localparam int CTRL_CLK = 1;
   localparam int CTRL_TC = 0;

   // Status register fields
   localparam int STAT_SIF = 7;
   localparam int STAT_OIF = 6;
   localparam int STAT_CNT_LO = 0;

   // Pin placement and port register fields
   localparam int PLACE_POS = 0;
   localparam int PORT_DAT_LO = 0;
   localparam int PORT_DIR_LO = 4;
   localparam int PIN_DI = 0;
   localparam int PIN_DO = 1;
   localparam int PIN_CK = 2;

   // Wire modes and clock sources
   localparam logic [1:0] WM_OFF = 2'h0;
   localparam logic [1:0] WM_THREE = 2'h1;
   localparam logic [1:0] WM_TWO = 2'h2;
   localparam logic [1:0] WM_TWO_HOLD = 2'h3;
   localparam logic [1:0] CS_SOFT = 2'h0;
   localparam logic [1:0] CS_TIMER = 2'h1;

   // Reset values and counter limit
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [3:0] CNT_RST = 4'h0;
   localparam logic [3:0] CNT_MAX = 4'hf;
   localparam logic [2:0] PORT_RST = 3'h0;

   // Outputs of one pin set; enables are active low
   typedef struct packed {
      logic di_out;
      logic di_oe_n;
      logic di_pullup;
      logic do_out;
      logic do_oe_n;
      logic ck_out;
      logic ck_oe_n;
      logic ck_pullup;
   } usc_pinset_s;

   localparam usc_pinset_s PINSET_IDLE = '{di_out: 1'b0, di_oe_n: 1'b1,
      di_pullup: 1'b0, do_out: 1'b0, do_oe_n: 1'b1, ck_out: 1'b0,
      ck_oe_n: 1'b1, ck_pullup: 1'b0};

endpackage

// >>> rtl/usc_ctrl.sv
// Serial shift control block: AHB-Lite registers, clocking, pin drive
`timescale 1ns/100ps
module usc_ctrl
   import usc_pkg::*;
#(
   parameter int DEC_W = 8
) (
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Timer compare match, same clock
   input wire logic tc0_match,
   // Port B pin set
   input wire logic pb_di_in,
   input wire logic pb_ck_in,
   output usc_pinset_s pb_pins,
   // Port A pin set
   input wire logic pa_di_in,
   input wire logic pa_ck_in,
   output usc_pinset_s pa_pins
);

   initial begin
      if (DEC_W < 5 || DEC_W > 32) begin
         $error("DEC_W must lie between 5 and 32");
      end
   end

   // Bus phase tracking
   logic wr_pend_q;
   logic rd_pend_q;
   logic [DEC_W-1:0] addr_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_mux;

   // Registers
   logic [1:0] ie_q;
   logic [1:0] wm_q;
   logic [1:0] cs_q;
   logic clksel_q;
   logic pos_q;
   logic start_q;
   logic ovf_q;
   logic [3:0] cnt_q;
   logic [7:0] data_q;
   logic dout_q;
   logic [2:0] port_q;
   logic [2:0] ddr_q;

   // Link sampling
   logic di_m_q;
   logic ck_m_q;
   logic di_s_q;
   logic ck_s_q;
   logic di_prev_q;
   logic ck_prev_q;

   // Decoded events
   logic [7:0] wd;
   logic ctrl_wr;
   logic place_wr;
   logic stat_wr;
   logic data_wr;
   logic port_wr;
   logic soft_tick;
   logic tog_wr;
   logic tog_cnt_tick;
   logic timer_tick;
   logic ck_rise;
   logic ck_fall;
   logic ext_shift;
   logic ext_latch;
   logic ext_cnt;
   logic shift_tick;
   logic shift_in;
   logic cnt_inc;
   logic cnt_wrap;
   logic start_det;
   logic hold;
   logic dout;
   usc_pinset_s act;

   function automatic logic hit(input logic [DEC_W-1:0] a,
                                input logic [7:0] ofs);
      hit = (a == DEC_W'(ofs));
   endfunction

   // Address phase; reads take one wait state so writes land first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= '0;
      end else if (ce) begin
         if (hsel && hready && htrans[1]) begin
            wr_pend_q <= hwrite;
            rd_pend_q <= !hwrite;
            addr_q <= haddr[DEC_W-1:0];
         end else begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= '0;
      end else if (ce && rd_pend_q) begin
         hrdata_q <= rd_mux;
      end
   end

   assign hreadyout = !rd_pend_q;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   assign wd = hwdata[7:0];
   assign ctrl_wr = wr_pend_q && hit(addr_q, CTRL_OFS);
   assign place_wr = wr_pend_q && hit(addr_q, PLACE_OFS);
   assign stat_wr = wr_pend_q && hit(addr_q, STAT_OFS);
   assign data_wr = wr_pend_q && hit(addr_q, DATA_OFS);
   assign port_wr = wr_pend_q && hit(addr_q, PORT_OFS);

   // Strobe bits are left out of the read mux, so they read as zero
   always_comb begin
      rd_mux = '0;
      if (hit(addr_q, CTRL_OFS)) begin
         rd_mux[CTRL_SIE] = ie_q[1];
         rd_mux[CTRL_OIE] = ie_q[0];
         rd_mux[CTRL_WM_LO+:2] = wm_q;
         rd_mux[CTRL_CS_LO+:2] = cs_q;
      end else if (hit(addr_q, PLACE_OFS)) begin
         rd_mux[PLACE_POS] = pos_q;
      end else if (hit(addr_q, STAT_OFS)) begin
         rd_mux[STAT_SIF] = start_q;
         rd_mux[STAT_OIF] = ovf_q;
         rd_mux[STAT_CNT_LO+:4] = cnt_q;
      end else if (hit(addr_q, DATA_OFS)) begin
         rd_mux[7:0] = data_q;
      end else if (hit(addr_q, PORT_OFS)) begin
         rd_mux[PORT_DAT_LO+:3] = port_q;
         rd_mux[PORT_DIR_LO+:3] = ddr_q;
      end
   end

   // Control and placement registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ie_q <= 2'h0;
         wm_q <= WM_OFF;
         cs_q <= CS_SOFT;
         clksel_q <= 1'b0;
         pos_q <= 1'b0;
      end else if (ce) begin
         if (ctrl_wr) begin
            ie_q <= {wd[CTRL_SIE], wd[CTRL_OIE]};
            wm_q <= wd[CTRL_WM_LO+:2];
            cs_q <= wd[CTRL_CS_LO+:2];
            clksel_q <= wd[CTRL_CLK];
         end
         if (place_wr) begin
            pos_q <= wd[PLACE_POS];
         end
      end
   end

   // Link inputs from the selected pin set, two flops deep
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         di_m_q <= 1'b1;
         ck_m_q <= 1'b1;
         di_s_q <= 1'b1;
         ck_s_q <= 1'b1;
         di_prev_q <= 1'b1;
         ck_prev_q <= 1'b1;
      end else if (ce) begin
         di_m_q <= pos_q ? pa_di_in : pb_di_in;
         ck_m_q <= pos_q ? pa_ck_in : pb_ck_in;
         di_s_q <= di_m_q;
         ck_s_q <= ck_m_q;
         di_prev_q <= di_s_q;
         ck_prev_q <= ck_s_q;
      end
   end

   assign ck_rise = ck_s_q && !ck_prev_q;
   assign ck_fall = !ck_s_q && ck_prev_q;

   // Clock source selection; new field value counts with its strobe
   assign soft_tick = ctrl_wr && wd[CTRL_CLK]
                      && wd[CTRL_CS_LO+:2] == CS_SOFT;
   assign tog_wr = ctrl_wr && wd[CTRL_TC];
   assign tog_cnt_tick = tog_wr && wd[CTRL_CS_LO+1]
                         && wd[CTRL_CLK];
   assign timer_tick = tc0_match && cs_q == CS_TIMER;
   assign ext_shift = cs_q[1]
                      && (cs_q[0] ? ck_fall : ck_rise);
   assign ext_latch = cs_q[1] && (cs_q[0] ? ck_rise : ck_fall);
   assign ext_cnt = cs_q[1] && !clksel_q
                    && (ck_rise || ck_fall);
   assign shift_tick = soft_tick || timer_tick || ext_shift;
   assign shift_in = soft_tick ? di_prev_q : di_s_q;
   assign cnt_inc = soft_tick || timer_tick || ext_cnt || tog_cnt_tick;
   assign cnt_wrap = cnt_inc && cnt_q == CNT_MAX && !stat_wr;

   // Counter; a software write overrides a coincident count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= CNT_RST;
      end else if (ce) begin
         if (stat_wr) begin
            cnt_q <= wd[STAT_CNT_LO+:4];
         end else if (cnt_inc) begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end

   // Sticky flags; a start beats a clear in the same cycle, any status write suppresses a wrap
   assign start_det = wm_q[1] && ck_s_q && !di_s_q
                      && di_prev_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_q <= 1'b0;
         ovf_q <= 1'b0;
      end else if (ce) begin
         if (start_det) begin
            start_q <= 1'b1;
         end else if (stat_wr && wd[STAT_SIF]) begin
            start_q <= 1'b0;
         end
         if (cnt_wrap) begin
            ovf_q <= 1'b1;
         end else if (stat_wr && wd[STAT_OIF]) begin
            ovf_q <= 1'b0;
         end
      end
   end

   // Data register and its output latch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_q <= BYTE_RST;
      end else if (ce) begin
         if (data_wr) begin
            data_q <= wd;
         end else if (shift_tick) begin
            data_q <= {data_q[6:0], shift_in};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dout_q <= 1'b0;
      end else if (ce && ext_latch) begin
         dout_q <= data_q[7];
      end
   end

   // Internal clocks see the latch as transparent
   assign dout = cs_q[1] ? dout_q : data_q[7];

   // Port bits and directions; toggle ignores direction
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_q <= PORT_RST;
         ddr_q <= PORT_RST;
      end else if (ce) begin
         if (port_wr) begin
            port_q <= wd[PORT_DAT_LO+:3];
            ddr_q <= wd[PORT_DIR_LO+:3];
         end else if (tog_wr) begin
            port_q[PIN_CK] <= !port_q[PIN_CK];
         end
      end
   end

   assign hold = start_q
                 || (wm_q == WM_TWO_HOLD && ovf_q);

   // Pin drive for the active set
   always_comb begin
      act.di_out = port_q[PIN_DI];
      act.di_oe_n = !ddr_q[PIN_DI];
      act.di_pullup = !ddr_q[PIN_DI] && port_q[PIN_DI];
      act.do_out = port_q[PIN_DO];
      act.do_oe_n = !ddr_q[PIN_DO];
      act.ck_out = port_q[PIN_CK];
      act.ck_oe_n = !ddr_q[PIN_CK];
      act.ck_pullup = !ddr_q[PIN_CK] && port_q[PIN_CK];
      unique case (wm_q)
         WM_OFF: begin
         end
         WM_THREE: begin
            act.do_out = dout;
         end
         WM_TWO, WM_TWO_HOLD: begin
            act.di_out = 1'b0;
            act.di_oe_n = !(ddr_q[PIN_DI]
                            && (!dout || !port_q[PIN_DI]));
            act.di_pullup = 1'b0;
            act.do_out = dout;
            act.ck_out = 1'b0;
            act.ck_oe_n = !(ddr_q[PIN_CK]
                            && (!port_q[PIN_CK] || hold));
            act.ck_pullup = 1'b0;
         end
      endcase
   end

   assign pb_pins = pos_q ? PINSET_IDLE : act;
   assign pa_pins = pos_q ? act : PINSET_IDLE;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_sda_pull_low: assert property (wm_q[1] && ddr_q[PIN_DI] && !dout
      |-> !act.di_oe_n && !act.di_out)
      else $error("SDA not pulled low for data zero");
   a_sda_release: assert property (wm_q[1] && dout && port_q[PIN_DI]
      |-> act.di_oe_n)
      else $error("SDA driven while it should be released");
   a_scl_start_hold: assert property (wm_q[1] && ddr_q[PIN_CK] && start_q
      |-> !act.ck_oe_n)
      else $error("SCL not held after start condition");
   a_scl_ovf_hold: assert property (wm_q == WM_TWO_HOLD && ddr_q[PIN_CK]
      && ovf_q |-> !act.ck_oe_n && !act.ck_out)
      else $error("SCL not held after overflow");
   a_pullups_off: assert property (wm_q[1]
      |-> !pb_pins.di_pullup && !pa_pins.ck_pullup
      && !pb_pins.ck_pullup)
      else $error("Pull-up left on in two-wire mode");
   a_off_mode_plain: assert property (wm_q == WM_OFF
      |-> act.do_out == port_q[PIN_DO] && act.ck_oe_n == !ddr_q[PIN_CK])
      else $error("Port pins altered in mode off");
   a_soft_strobe_count: assert property (ce && soft_tick && !stat_wr
      |=> cnt_q == $past(cnt_q) + 4'h1 && data_q[0] == $past(di_prev_q))
      else $error("Soft strobe did not shift and count");
   a_timer_once: assert property (ce && cs_q == CS_TIMER && tc0_match
      && !stat_wr && !ctrl_wr |=> cnt_q == $past(cnt_q) + 4'h1)
      else $error("Timer match did not count once");
   a_wrap_sets_ovf: assert property (ce && cnt_inc && cnt_q == CNT_MAX
      && !stat_wr |=> ovf_q && cnt_q == CNT_RST)
      else $error("Counter wrap missed overflow flag");
   a_toggle_inverts: assert property (ce && tog_wr && !port_wr
      |=> port_q[PIN_CK] != $past(port_q[PIN_CK]))
      else $error("Toggle did not invert clock port bit");
   a_start_sticky: assert property (start_q && !(stat_wr && wd[STAT_SIF])
      |=> start_q)
      else $error("Start flag cleared without write one");
   a_place_rsvd: assert property (ce && rd_pend_q
      && hit(addr_q, PLACE_OFS) |=> hrdata_q[31:1] == 31'h0)
      else $error("Placement reserved bits not zero");

endmodule

// >>> test/usc_peer.sv
// Two-wire peer model: open-drain bus lines with pull-ups, clock maker
`timescale 1ns/100ps
module usc_peer
   import usc_pkg::*;
(
   // Design pin sets
   input wire usc_pinset_s pb,
   input wire usc_pinset_s pa,
   // Peer data pull
   input wire logic sda_low,
   // Wire levels
   output logic sda,
   output logic scl
);
   logic scl_drv = 1'b1;
   // Released lines go high by the bus pull-ups
   assign sda = (pb.di_oe_n | pb.di_out) & (pa.di_oe_n | pa.di_out)
      & ~sda_low;
   assign scl = (pb.ck_oe_n | pb.ck_out) & (pa.ck_oe_n | pa.ck_out)
      & scl_drv;
   // Clock runs only inside a frame, stands high between frames
   task automatic pulses(input int n);
      repeat (n) begin
         #80 scl_drv = 1'b0;
         #80 scl_drv = 1'b1;
      end
   endtask
endmodule

// >>> test/usc_ctrl_tb.sv
// Self-checking bench for the serial shift control block
`timescale 1ns/100ps
module usc_ctrl_tb
   import usc_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, tc0_match, sda_low;
   logic [31:0] haddr, hwdata, hrdata, rv;
   logic [1:0] htrans;
   logic hreadyout, hresp, sda, scl;
   usc_pinset_s pb_pins, pa_pins;
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int exp_data;
   // Bus answer as it stands just before the next rising edge
   logic rdy_s = 1'b1;
   logic [31:0] rdata_s = 32'h0;
   logic [31:0] rnd = 32'h79e8;
   logic [7:0] ofs [6] = '{CTRL_OFS, PLACE_OFS, STAT_OFS, DATA_OFS,
      PORT_OFS, 8'h14};

   usc_ctrl usc_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .tc0_match(tc0_match), .pb_di_in(sda), .pb_ck_in(scl),
      .pb_pins(pb_pins), .pa_di_in(sda), .pa_ck_in(scl),
      .pa_pins(pa_pins));
   usc_peer usc_peer_inst (.pb(pb_pins), .pa(pa_pins), .sda_low(sda_low),
      .sda(sda), .scl(scl));

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [7:0] ctl(input logic [1:0] wm,
      input logic [1:0] cs, input logic ck, input logic tc);
      return {2'b11, wm, cs, ck, tc};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Sampling at the falling edge avoids racing the slave's own flops
   always @(negedge hclk) begin
      rdy_s <= hreadyout;
      rdata_s <= hrdata;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= 1'b1;
      do @(posedge hclk); while (rdy_s !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (rdy_s !== 1'b1);
   endtask

   task automatic rd(input logic [7:0] a);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= 1'b0;
      do @(posedge hclk); while (rdy_s !== 1'b1);
      htrans <= 2'b00;
      do @(posedge hclk); while (rdy_s !== 1'b1);
      rv = rdata_s;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rv, e);
   endtask

   // Lets register updates of the last edge land before pins are looked at
   task automatic settle;
      @(posedge hclk);
      #1;
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Whole run needs well under 3000 cycles
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fail_count++;
         results();
      end
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      tc0_match = 1'b0;
      sda_low = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (ofs[i]) rchk(ofs[i], 32'h0);
      wr(PLACE_OFS, 8'hff);
      rchk(PLACE_OFS, 32'h1);
      wr(8'h14, 8'hff);
      rchk(8'h14, 32'h0);
      wr(PLACE_OFS, 8'h00);
      $display("done: registers");
      rnd = lfsr(rnd);
      exp_data = rnd[7:0];
      wr(DATA_OFS, rnd[7:0]);
      wr(CTRL_OFS, ctl(WM_OFF, CS_SOFT, 1'b0, 1'b0));
      rchk(DATA_OFS, exp_data);
      for (int b = 0; b < 2; b++) begin
         sda_low <= b[0];
         repeat (4) @(posedge hclk);
         wr(CTRL_OFS, ctl(WM_OFF, CS_SOFT, 1'b1, 1'b0));
         exp_data = ((exp_data << 1) | (b ^ 1)) & 'hff;
      end
      rchk(DATA_OFS, exp_data);
      rchk(STAT_OFS, 32'h2);
      rchk(CTRL_OFS, 32'hc0);
      $display("done: soft strobe");
      sda_low <= 1'b0;
      wr(STAT_OFS, 8'h00);
      wr(CTRL_OFS, ctl(WM_OFF, CS_SOFT, 1'b0, 1'b1));
      rchk(PORT_OFS, 32'h4);
      rchk(CTRL_OFS, 32'hc0);
      wr(CTRL_OFS, ctl(WM_OFF, 2'h2, 1'b1, 1'b1));
      rchk(PORT_OFS, 32'h0);
      rchk(STAT_OFS, 32'h1);
      wr(CTRL_OFS, ctl(WM_OFF, 2'h2, 1'b0, 1'b1));
      rd(STAT_OFS);
      chk(rv[3:0], 4'h1);
      $display("done: toggle");
      wr(STAT_OFS, 8'hc0);
      wr(CTRL_OFS, ctl(WM_OFF, CS_TIMER, 1'b1, 1'b0));
      for (int k = 0; k < 3; k++) begin
         tc0_match <= 1'b1;
         @(posedge hclk);
         tc0_match <= 1'b0;
         repeat (3) @(posedge hclk);
         exp_data = ((exp_data << 1) | 1) & 'hff;
      end
      rchk(STAT_OFS, 32'h3);
      rchk(DATA_OFS, exp_data);
      $display("done: timer");
      wr(CTRL_OFS, ctl(WM_OFF, 2'h2, 1'b0, 1'b0));
      usc_peer_inst.pulses(4);
      repeat (4) @(posedge hclk);
      exp_data = ((exp_data << 4) | 'hf) & 'hff;
      rd(STAT_OFS);
      chk(rv[3:0], 4'h3 + 4'h8);
      rchk(DATA_OFS, exp_data);
      sda_low <= 1'b1;
      wr(CTRL_OFS, ctl(WM_OFF, 2'h3, 1'b0, 1'b0));
      usc_peer_inst.pulses(2);
      repeat (4) @(posedge hclk);
      exp_data = (exp_data << 2) & 'hff;
      rchk(DATA_OFS, exp_data);
      rd(STAT_OFS);
      chk(rv[3:0], 4'hf);
      sda_low <= 1'b0;
      $display("done: external clock");
      wr(PORT_OFS, 8'h44);
      wr(CTRL_OFS, ctl(WM_TWO_HOLD, CS_SOFT, 1'b0, 1'b0));
      wr(STAT_OFS, 8'hcf);
      wr(CTRL_OFS, ctl(WM_TWO_HOLD, CS_SOFT, 1'b1, 1'b0));
      rchk(STAT_OFS, 32'h40);
      settle();
      chk(pb_pins.ck_oe_n, 1'b0);
      wr(STAT_OFS, 8'h40);
      settle();
      chk(pb_pins.ck_oe_n, 1'b1);
      chk({pb_pins.di_pullup, pb_pins.ck_pullup}, 2'b00);
      $display("done: overflow hold");
      wr(CTRL_OFS, ctl(WM_TWO, CS_SOFT, 1'b0, 1'b0));
      // Data falls while the clock line is high
      sda_low <= 1'b1;
      repeat (6) @(posedge hclk);
      rd(STAT_OFS);
      chk(rv[7], 1'b1);
      repeat (20) @(posedge hclk);
      settle();
      chk(pb_pins.ck_oe_n, 1'b0);
      wr(STAT_OFS, 8'h80);
      settle();
      chk(pb_pins.ck_oe_n, 1'b1);
      sda_low <= 1'b0;
      $display("done: start hold");
      for (int i = 0; i < 4; i++) begin
         wr(DATA_OFS, {i[0], 7'h0});
         wr(PORT_OFS, {7'h08, i[1]});
         settle();
         chk(~pb_pins.di_oe_n, ~(i[0] & i[1]));
      end
      wr(PORT_OFS, 8'h00);
      settle();
      chk(pb_pins.di_oe_n, 1'b1);
      wr(STAT_OFS, 8'hc0);
      wr(PORT_OFS, 8'h40);
      settle();
      chk(pb_pins.ck_oe_n, 1'b0);
      chk(pa_pins, PINSET_IDLE);
      wr(PLACE_OFS, 8'h01);
      settle();
      chk(pa_pins.ck_oe_n, 1'b0);
      chk(pb_pins, PINSET_IDLE);
      $display("done: pin drive");
      // Three-wire master makes clock by toggling its own port bit
      wr(CTRL_OFS, ctl(WM_THREE, CS_SOFT, 1'b0, 1'b1));
      settle();
      chk(pa_pins.ck_out, 1'b1);
      chk(pa_pins.ck_oe_n, 1'b0);
      chk(pa_pins.do_out, 1'b1);
      $display("done: three-wire");
      wr(PORT_OFS, 8'h00);
      wr(CTRL_OFS, ctl(WM_OFF, CS_SOFT, 1'b0, 1'b0));
      wr(STAT_OFS, 8'hc0);
      sda_low <= 1'b1;
      repeat (6) @(posedge hclk);
      rd(STAT_OFS);
      chk(rv[7], 1'b0);
      chk({pa_pins, pb_pins}, {PINSET_IDLE, PINSET_IDLE});
      $display("done: mode off");
      results();
   end
endmodule
